// ===== smc_clk_if.sv
`timescale 1ns/1ps
interface smc_clk_if;
    logic       enable;
    logic       fc_tick;
    logic [2:0] hs_sel;
    logic [4:0] m_val;
    logic [7:0] n_val;
    logic       clk_level;

    modport ctrl (output enable, output fc_tick, output hs_sel, output m_val, output n_val,
                  input clk_level);
    modport gen  (input enable, input fc_tick, input hs_sel, input m_val, input n_val,
                  output clk_level);
endinterface

// ===== smc_frac_div.sv
`timescale 1ns/1ps
module smc_frac_div (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // divider controls and clock level
    smc_clk_if.gen    cif
);

    logic [15:0] hs_cnt;
    logic [15:0] next_hs_cnt;
    logic [8:0]  acc;
    logic [8:0]  next_acc;
    logic        level;
    logic        next_level;
    logic        hs_tick;

    // divide ratio of the high speed stage is 1 << select, capped at 16
    function automatic logic [15:0] hs_ratio(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > smc_pkg::HS_SEL_MAX) ? smc_pkg::HS_SEL_MAX : sel;
        return 16'h0001 << s;
    endfunction

    // high speed stage, then M/N phase accumulator toggling the clock
    // a toggle per overflow gives one period per two overflows, so step is 2*M;
    // when 2*M exceeds N only one toggle per step happens, so M/N above 1/2 saturates
    always_comb begin
        logic [8:0] sum;
        logic [8:0] n_eff;
        sum         = 9'h000;
        n_eff       = (cif.n_val == 8'h00) ? 9'h001 : {1'b0, cif.n_val};
        next_hs_cnt = hs_cnt;
        next_acc    = acc;
        next_level  = level;
        hs_tick     = 1'b0;
        if (!cif.enable) begin
            next_hs_cnt = 16'h0000;
            next_acc    = 9'h000;
            next_level  = 1'b0;
        end else if (cif.fc_tick) begin
            if (hs_cnt + 16'h0001 >= hs_ratio(cif.hs_sel)) begin
                next_hs_cnt = 16'h0000;
                hs_tick     = 1'b1;
            end else begin
                next_hs_cnt = hs_cnt + 16'h0001;
            end
        end
        if (cif.enable && hs_tick) begin
            sum = acc + {3'b000, cif.m_val, 1'b0};
            if (sum >= n_eff) begin
                next_acc   = sum - n_eff;
                next_level = ~level;
            end else begin
                next_acc = sum;
            end
        end
    end

    // register divider state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hs_cnt <= 16'h0000;
            acc    <= 9'h000;
            level  <= 1'b0;
        end else begin
            hs_cnt <= next_hs_cnt;
            acc    <= next_acc;
            level  <= next_level;
        end
    end

    assign cif.clk_level = level;

    // clock edges only follow a high speed divider tick
    a_edge_on_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        (cif.enable && $past(cif.enable) && $changed(level)) |-> $past(hs_tick))
        else $error("clock toggled without a high speed divider tick");

endmodule

// ===== smc_pkg.sv
package smc_pkg;

    // register offsets on the documented register port
    localparam logic [7:0] MODE_SEL_ADDR  = 8'h03;
    localparam logic [7:0] DIV_CFG_A_ADDR = 8'h06;
    localparam logic [7:0] DIV_CFG_B_ADDR = 8'h07;

    // mode select register layout
    localparam int MODE_LSB     = 0;
    localparam int MODE_MSB     = 2;
    localparam int OVERRIDE_BIT = 4;

    // divider config a layout: [7:5] high speed divider select, [4:0] M
    localparam int HS_SEL_LSB = 5;
    localparam int HS_SEL_MSB = 7;
    localparam int M_LSB      = 0;
    localparam int M_MSB      = 4;

    // reset values (high speed divider select 2 gives divide by 4)
    localparam logic [7:0] DIV_CFG_A_RESET = 8'h41;
    localparam logic [7:0] DIV_CFG_B_RESET = 8'h01;
    localparam logic [2:0] HS_SEL_MAX      = 3'h4;

    // operating mode codes
    localparam logic [2:0] MODE_SYNC     = 3'h0;
    localparam logic [2:0] MODE_EXT_CLK  = 3'h2;
    localparam logic [2:0] MODE_INT_OSC  = 3'h3;
    localparam logic [2:0] MODE_PAR_COMP = 3'h5;

    // control bus device addresses
    localparam logic [6:0] BUS_ADDR_LOW  = 7'h18;
    localparam logic [6:0] BUS_ADDR_HIGH = 7'h19;

    // address strap levels
    localparam logic [2:0] ADDR_LVL_1 = 3'h1;
    localparam logic [2:0] ADDR_LVL_2 = 3'h2;
    localparam logic [2:0] ADDR_LVL_3 = 3'h3;
    localparam logic [2:0] ADDR_LVL_4 = 3'h4;

    // configuration phase states
    typedef enum logic [1:0] {
        ST_STRAP = 2'b01,
        ST_RUN   = 2'b10
    } smc_state_type;

endpackage

// ===== smc_sensor_model.sv
`timescale 1ns/1ps
// image sensor side: counts reference clock rising edges while the pin is driven
module smc_sensor_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // reference clock pin and its enable
    input  wire logic        ref_clk_i,
    input  wire logic        ref_clk_oe_i,
    // count control and result
    input  wire logic        clear_i,
    output logic      [15:0] edge_count_o
);
    logic        last_level;
    logic        next_last_level;
    logic [15:0] next_edge_count;

    // an undriven pin counts nothing, so a released output can never pass for a clock
    always_comb begin
        next_last_level = ref_clk_oe_i & ref_clk_i;
        next_edge_count = edge_count_o;
        if (clear_i) begin
            next_edge_count = 16'h0000;
        end else if (ref_clk_oe_i && ref_clk_i && !last_level) begin
            next_edge_count = edge_count_o + 16'h0001;
        end
    end

    // edge history and count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_level   <= 1'b0;
            edge_count_o <= 16'h0000;
        end else begin
            last_level   <= next_last_level;
            edge_count_o <= next_edge_count;
        end
    end
endmodule

// ===== smc_strap_clk_ctrl.sv
`timescale 1ns/1ps
module smc_strap_clk_ctrl (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // pins and strap comparators
    input  wire logic       powerdown_release_input_i,
    input  wire logic [2:0] mode_strap_i,
    input  wire logic [2:0] address_strap_input_i,
    output logic            shared_strap_clock_pin_o,
    output logic            shared_strap_clock_pin_oe_o,
    // forward channel rate enable, same clock domain
    input  wire logic       forward_channel_rate_tick_i,
    // register port
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic [7:0]      reg_rdata_o,
    // configuration results
    output logic [6:0]      device_address_o,
    output logic            bus_io_3v3_o,
    output logic [2:0]      mode_o,
    output logic            ref_from_back_channel_o,
    output logic            ref_from_external_input_o,
    output logic            ref_from_always_on_oscillator_o,
    output logic            parallel_video_compat_mode_o,
    // data format request check
    input  wire logic       raw12_low_frequency_format_req_i,
    output logic            raw12_low_frequency_format_reject_o
);

    smc_clk_if cif ();

    smc_pkg::smc_state_type state;
    smc_pkg::smc_state_type next_state;

    logic [2:0] pdb_sync;
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic [2:0] addr_s1;
    logic [2:0] addr_s2;
    logic       pdb_rise;
    logic [2:0] mode;
    logic [2:0] next_mode;
    logic       override;
    logic       next_override;
    logic [2:0] addr_level;
    logic [2:0] next_addr_level;
    logic [7:0] cfg_a;
    logic [7:0] next_cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] next_cfg_b;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic       clk_out_allowed;

    // two flops on every pin; pdb_sync[2] is only an edge history bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pdb_sync <= 3'h0;
            mode_s1  <= 3'h0;
            mode_s2  <= 3'h0;
            addr_s1  <= 3'h0;
            addr_s2  <= 3'h0;
        end else begin
            pdb_sync <= {pdb_sync[1:0], powerdown_release_input_i};
            mode_s1  <= mode_strap_i;
            mode_s2  <= mode_s1;
            addr_s1  <= address_strap_input_i;
            addr_s2  <= addr_s1;
        end
    end

    assign pdb_rise = pdb_sync[1] & ~pdb_sync[2];

    // address strap level to bus address
    function automatic logic [6:0] addr_of_level(input logic [2:0] lvl);
        return (lvl == smc_pkg::ADDR_LVL_2 || lvl == smc_pkg::ADDR_LVL_4) ?
               smc_pkg::BUS_ADDR_HIGH : smc_pkg::BUS_ADDR_LOW;
    endfunction

    // register write decode, used by several registers
    function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] t);
        return wr && (a == t);
    endfunction

    // configuration phase, strap latching and register writes
    // strap latch wins over a same-cycle register write: power-up owns the mode
    always_comb begin
        next_state      = state;
        next_mode       = mode;
        next_override   = override;
        next_addr_level = addr_level;
        next_cfg_a      = cfg_a;
        next_cfg_b      = cfg_b;
        unique case (state)
            smc_pkg::ST_STRAP: begin
                if (pdb_rise) begin
                    next_mode       = mode_s2;
                    next_addr_level = addr_s2;
                    next_override   = 1'b0;
                    next_state      = smc_pkg::ST_RUN;
                end
            end
            smc_pkg::ST_RUN: begin
                if (!pdb_sync[1]) begin
                    next_state = smc_pkg::ST_STRAP;
                end
            end
        endcase
        if (state == smc_pkg::ST_RUN && pdb_sync[1]) begin
            if (wr_hit(reg_wr_i, reg_addr_i, smc_pkg::MODE_SEL_ADDR)) begin
                next_override = reg_wdata_i[smc_pkg::OVERRIDE_BIT];
                if (reg_wdata_i[smc_pkg::OVERRIDE_BIT]) begin
                    next_mode = reg_wdata_i[smc_pkg::MODE_MSB:smc_pkg::MODE_LSB];
                end
            end
        end
        if (wr_hit(reg_wr_i, reg_addr_i, smc_pkg::DIV_CFG_A_ADDR)) begin
            next_cfg_a = reg_wdata_i;
        end
        if (wr_hit(reg_wr_i, reg_addr_i, smc_pkg::DIV_CFG_B_ADDR)) begin
            next_cfg_b = reg_wdata_i;
        end
    end

    // register configuration state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state      <= smc_pkg::ST_STRAP;
            mode       <= smc_pkg::MODE_SYNC;
            override   <= 1'b0;
            addr_level <= smc_pkg::ADDR_LVL_1;
            cfg_a      <= smc_pkg::DIV_CFG_A_RESET;
            cfg_b      <= smc_pkg::DIV_CFG_B_RESET;
        end else begin
            state      <= next_state;
            mode       <= next_mode;
            override   <= next_override;
            addr_level <= next_addr_level;
            cfg_a      <= next_cfg_a;
            cfg_b      <= next_cfg_b;
        end
    end

    // read data, one cycle after the read strobe; unmapped reads return zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                smc_pkg::MODE_SEL_ADDR:  next_rdata = {3'h0, override, 1'b0, mode};
                smc_pkg::DIV_CFG_A_ADDR: next_rdata = cfg_a;
                smc_pkg::DIV_CFG_B_ADDR: next_rdata = cfg_b;
                default:                 next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign reg_rdata_o = rdata;

    // reference source decode from the current mode
    assign ref_from_back_channel_o         = (mode == smc_pkg::MODE_SYNC);
    assign ref_from_external_input_o       = (mode == smc_pkg::MODE_EXT_CLK) ||
                                             (mode == smc_pkg::MODE_PAR_COMP);
    assign ref_from_always_on_oscillator_o = (mode == smc_pkg::MODE_INT_OSC);
    assign parallel_video_compat_mode_o    = (mode == smc_pkg::MODE_PAR_COMP);
    assign mode_o                          = mode;

    // raw12 low frequency data cannot be carried in compatibility mode
    assign raw12_low_frequency_format_reject_o = parallel_video_compat_mode_o &&
                                                 raw12_low_frequency_format_req_i;

    // bus address and signalling level from the latched address strap
    assign device_address_o = addr_of_level(addr_level);
    assign bus_io_3v3_o     = (addr_level == smc_pkg::ADDR_LVL_3) ||
                              (addr_level == smc_pkg::ADDR_LVL_4);

    // clock only on a valid mode that has a link reference for the sensor
    // undefined mode codes keep the pin quiet rather than guess a source
    assign clk_out_allowed = (state == smc_pkg::ST_RUN) &&
                             (ref_from_back_channel_o || ref_from_external_input_o);

    assign cif.enable  = clk_out_allowed;
    assign cif.fc_tick = forward_channel_rate_tick_i;
    assign cif.hs_sel  = cfg_a[smc_pkg::HS_SEL_MSB:smc_pkg::HS_SEL_LSB];
    assign cif.m_val   = cfg_a[smc_pkg::M_MSB:smc_pkg::M_LSB];
    assign cif.n_val   = cfg_b;

    smc_frac_div u_div (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cif   (cif)
    );

    // pin is released during strap sampling so the strap sets its level
    assign shared_strap_clock_pin_oe_o = clk_out_allowed;
    assign shared_strap_clock_pin_o    = clk_out_allowed & cif.clk_level;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_osc_clock_off: assert property (
        (mode == smc_pkg::MODE_INT_OSC) |-> !shared_strap_clock_pin_oe_o)
        else $error("sensor clock driven in oscillator mode");

    a_strap_mode_latch: assert property (
        (state == smc_pkg::ST_STRAP && pdb_rise) |=> (mode == $past(mode_s2)) &&
            (state == smc_pkg::ST_RUN))
        else $error("strapped mode not latched on release");

    a_mode_read_only: assert property (
        (state == smc_pkg::ST_RUN && pdb_sync[1] && reg_wr_i &&
         reg_addr_i == smc_pkg::MODE_SEL_ADDR && !reg_wdata_i[smc_pkg::OVERRIDE_BIT])
        |=> $stable(mode))
        else $error("mode changed without override");

    a_mode_override_wr: assert property (
        (state == smc_pkg::ST_RUN && pdb_sync[1] && reg_wr_i &&
         reg_addr_i == smc_pkg::MODE_SEL_ADDR && reg_wdata_i[smc_pkg::OVERRIDE_BIT])
        |=> (mode == $past(reg_wdata_i[smc_pkg::MODE_MSB:smc_pkg::MODE_LSB])) && override)
        else $error("override write not taken");

    a_mode_readback: assert property (
        (reg_rd_i && reg_addr_i == smc_pkg::MODE_SEL_ADDR && !reg_wr_i && $stable(mode))
        |=> (reg_rdata_o[2:0] == $past(mode)) &&
            (reg_rdata_o[smc_pkg::OVERRIDE_BIT] == $past(override)))
        else $error("mode read back wrong");

    a_addr_select: assert property (
        (state == smc_pkg::ST_RUN) |-> device_address_o ==
            (((addr_level == 3'h2) || (addr_level == 3'h4)) ? 7'h19 : 7'h18))
        else $error("bus address does not follow strap");

    a_pin_strap_phase: assert property (
        (state == smc_pkg::ST_STRAP) |-> !shared_strap_clock_pin_oe_o && !shared_strap_clock_pin_o)
        else $error("shared pin driven during strap sampling");

    a_ref_source_sel: assert property (
        $onehot0({ref_from_back_channel_o, ref_from_external_input_o,
                  ref_from_always_on_oscillator_o}) &&
        (mode == 3'h0) == ref_from_back_channel_o &&
        (mode == 3'h3) == ref_from_always_on_oscillator_o)
        else $error("reference source decode wrong");

    a_raw12_reject: assert property (
        (mode == 3'h5 && raw12_low_frequency_format_req_i) |-> raw12_low_frequency_format_reject_o)
        else $error("raw12 low frequency accepted in compatibility mode");

    // power-up owns the mode: a strap-phase write must not leak into it
    a_strap_wr_ignored: assert property (
        (state == smc_pkg::ST_STRAP && !pdb_rise && reg_wr_i &&
         reg_addr_i == smc_pkg::MODE_SEL_ADDR) |=> $stable(mode) && $stable(override))
        else $error("mode written during strap phase");

    // bus address level latched together with the mode
    a_addr_latch: assert property (
        (state == smc_pkg::ST_STRAP && pdb_rise)
        |=> addr_level == $past(addr_s2))
        else $error("address strap not latched on release");

    // power-down drops back to strap sampling and keeps the mode
    a_release_to_strap: assert property (
        (state == smc_pkg::ST_RUN && !pdb_sync[1])
        |=> (state == smc_pkg::ST_STRAP) && $stable(mode))
        else $error("power-down did not return to strap phase");

    // divider settings take the written byte whole
    a_cfg_a_write: assert property (
        (reg_wr_i && reg_addr_i == smc_pkg::DIV_CFG_A_ADDR)
        |=> cfg_a == $past(reg_wdata_i))
        else $error("divider config a write lost");

    // N register also writable at any time, strap phase included
    a_cfg_b_write: assert property (
        (reg_wr_i && reg_addr_i == smc_pkg::DIV_CFG_B_ADDR)
        |=> cfg_b == $past(reg_wdata_i))
        else $error("divider config b write lost");

endmodule

// ===== smc_strap_clk_ctrl_test.sv
`timescale 1ns/1ps
module smc_strap_clk_ctrl_test;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        powerdown_release_input = 1'b0;
    logic [2:0]  mode_strap = 3'h0;
    logic [2:0]  addr_strap = 3'h1;
    logic        pin;
    logic        pin_oe;
    logic        fc_tick = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic [6:0]  dev_addr;
    logic        io_3v3;
    logic [2:0]  mode;
    logic        ref_bc;
    logic        ref_ext;
    logic        ref_osc;
    logic        par_mode;
    logic        raw12_req = 1'b0;
    logic        raw12_rej;
    logic        clr = 1'b0;
    logic [15:0] edges;
    int          err_total = 0;
    int          n_checks = 0;
    int          cycles = 0;

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    smc_strap_clk_ctrl smc_strap_clk_ctrl_inst (
        .clk_i                               (clk_i),
        .rst_i                               (rst_i),
        .powerdown_release_input_i           (powerdown_release_input),
        .mode_strap_i                        (mode_strap),
        .address_strap_input_i               (addr_strap),
        .shared_strap_clock_pin_o            (pin),
        .shared_strap_clock_pin_oe_o         (pin_oe),
        .forward_channel_rate_tick_i         (fc_tick),
        .reg_wr_i                            (reg_wr),
        .reg_rd_i                            (reg_rd),
        .reg_addr_i                          (reg_addr),
        .reg_wdata_i                         (reg_wdata),
        .reg_rdata_o                         (reg_rdata),
        .device_address_o                    (dev_addr),
        .bus_io_3v3_o                        (io_3v3),
        .mode_o                              (mode),
        .ref_from_back_channel_o             (ref_bc),
        .ref_from_external_input_o           (ref_ext),
        .ref_from_always_on_oscillator_o     (ref_osc),
        .parallel_video_compat_mode_o        (par_mode),
        .raw12_low_frequency_format_req_i    (raw12_req),
        .raw12_low_frequency_format_reject_o (raw12_rej)
    );

    smc_sensor_model smc_sensor_model_inst (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .ref_clk_i    (pin),
        .ref_clk_oe_i (pin_oe),
        .clear_i      (clr),
        .edge_count_o (edges)
    );

    // verdict and end of run
    task automatic test_done();
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // register port: one-cycle strobes launched at the falling edge
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk_i);
        reg_wr = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk_i);
        reg_rd = 1'b0;
        d      = reg_rdata;
    endtask

    // register defaults and an unmapped read
    task automatic test_defaults();
        logic [7:0] d;
        reg_read(smc_pkg::DIV_CFG_A_ADDR, d);
        check("cfg_a reset", d, smc_pkg::DIV_CFG_A_RESET);
        reg_read(smc_pkg::DIV_CFG_B_ADDR, d);
        check("cfg_b reset", d, smc_pkg::DIV_CFG_B_RESET);
        reg_read(8'h55, d);
        check("unmapped read", d, 8'h00);
    endtask

    // each defined mode code paired with one address level, latched on power-up
    task automatic test_straps();
        logic [2:0] modes [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
        logic [3:0] flags [4] = '{4'h8, 4'h4, 4'h2, 4'h5};
        logic [7:0] d;
        logic [2:0] prev = smc_pkg::MODE_SYNC;
        for (int i = 0; i < 4; i++) begin
            powerdown_release_input = 1'b0;
            repeat (4) @(negedge clk_i);
            check("oe in strap phase", {7'h00, pin_oe}, 8'h00);
            reg_write(smc_pkg::MODE_SEL_ADDR, 8'h13);
            check("strap phase write", {5'h00, mode}, {5'h00, prev});
            mode_strap = modes[i];
            addr_strap = 3'(i + 1);
            repeat (3) @(negedge clk_i);
            powerdown_release_input = 1'b1;
            repeat (5) @(negedge clk_i);
            check("mode", {5'h00, mode}, {5'h00, modes[i]});
            check("ref flags", {4'h0, ref_bc, ref_ext, ref_osc, par_mode},
                  {4'h0, flags[i]});
            check("oe", {7'h00, pin_oe}, {7'h00, modes[i] != 3'h3});
            check("address", {1'b0, dev_addr}, (i % 2) ? 8'h19 : 8'h18);
            check("io 3v3", {7'h00, io_3v3}, {7'h00, i >= 2});
            reg_read(smc_pkg::MODE_SEL_ADDR, d);
            check("mode readback", d, {5'h00, modes[i]});
            prev = modes[i];
        end
    endtask

    // override writes and the raw12 format refusal
    task automatic test_override();
        logic [7:0] d;
        reg_write(smc_pkg::MODE_SEL_ADDR, 8'h10);
        raw12_req = 1'b1;
        @(negedge clk_i);
        check("mode 0 override", {5'h00, mode}, 8'h00);
        check("raw12 in mode 0", {7'h00, raw12_rej}, 8'h00);
        reg_write(smc_pkg::MODE_SEL_ADDR, 8'h15);
        reg_read(smc_pkg::MODE_SEL_ADDR, d);
        check("mode 5 readback", d, 8'h15);
        check("raw12 in mode 5", {7'h00, raw12_rej}, 8'h01);
        reg_write(smc_pkg::MODE_SEL_ADDR, 8'h02);
        reg_read(smc_pkg::MODE_SEL_ADDR, d);
        check("locked mode", d, 8'h05);
        raw12_req = 1'b0;
    endtask

    // counts sensor clock edges over 400 rate ticks
    task automatic measure(input logic [7:0] lo, input logic [7:0] hi);
        @(negedge clk_i);
        clr = 1'b1;
        @(negedge clk_i);
        clr = 1'b0;
        repeat (400) @(negedge clk_i);
        check("edge count", {7'h00, edges >= 16'(lo) && edges <= 16'(hi)}, 8'h01);
    endtask

    // integer N/M with small dividers keeps the synthesis stage in range
    task automatic test_clock();
        reg_write(smc_pkg::MODE_SEL_ADDR, 8'h10);
        fc_tick = 1'b1;
        reg_write(smc_pkg::DIV_CFG_A_ADDR, 8'h01);
        reg_write(smc_pkg::DIV_CFG_B_ADDR, 8'h04);
        measure(8'h62, 8'h65);
        reg_write(smc_pkg::DIV_CFG_A_ADDR, 8'h21);
        measure(8'h30, 8'h33);
        reg_write(smc_pkg::MODE_SEL_ADDR, 8'h13);
        measure(8'h00, 8'h00);
        check("oe in oscillator mode", {7'h00, pin_oe}, 8'h00);
        reg_write(smc_pkg::MODE_SEL_ADDR, 8'h11);
        check("oe in undefined mode", {7'h00, pin_oe}, 8'h00);
        fc_tick = 1'b0;
    endtask

    // hang guard well above the expected run of about 1300 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        test_defaults();
        test_straps();
        test_override();
        test_clock();
        test_done();
    end
endmodule
